// >>> design/serial_slave_pkg.sv
// Constants, state type and reset image of the two-wire slave control block
package serial_slave_pkg;

    // ********************************************************
    // Register indices on the plain register port
    // ********************************************************
    localparam logic [1:0] ADDR_OWN = 2'h0;
    localparam logic [1:0] ADDR_CTRL0 = 2'h1;
    localparam logic [1:0] ADDR_STAT = 2'h2;
    localparam logic [1:0] ADDR_DATA = 2'h3;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int OWN_MSB = 7;
    localparam int OWN_LSB = 1;
    localparam int SPARE_BIT = 0;
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 5;
    localparam int DEB_MSB = 3;
    localparam int DEB_LSB = 2;
    localparam int EN_BIT = 1;
    localparam int ICF_BIT = 0;
    localparam int HCF_BIT = 7;
    localparam int ADDRESS_MATCH_FLAG_BIT = 6;
    localparam int HBB_BIT = 5;
    localparam int HTX_BIT = 4;
    localparam int ACK_SEND_BIT_BIT = 3;
    localparam int SRW_BIT = 2;
    localparam int MATCH_WAKEUP_ENABLE_BIT = 1;
    localparam int ACK_RECEIVED_FLAG_BIT = 0;

    // ********************************************************
    // Mode and debounce codes
    // ********************************************************
    localparam logic [2:0] MODE_SPI_DIV4 = 3'h0;
    localparam logic [2:0] MODE_SPI_DIV16 = 3'h1;
    localparam logic [2:0] MODE_SPI_DIV64 = 3'h2;
    localparam logic [2:0] MODE_SPI_SUB = 3'h3;
    localparam logic [2:0] MODE_SPI_PTM = 3'h4;
    localparam logic [2:0] MODE_SPI_SLAVE = 3'h5;
    localparam logic [2:0] MODE_I2C = 3'h6;
    localparam logic [2:0] MODE_UNUSED = 3'h7;
    localparam logic [1:0] DEB_NONE = 2'h0;
    localparam logic [1:0] DEB_TWO = 2'h1;
    localparam logic [2:0] DEB_TWO_CYC = 3'h2;
    localparam logic [2:0] DEB_FOUR_CYC = 3'h4;

    // Half-periods of the divided SPI clock, minus one
    localparam logic [5:0] HALF_DIV4 = 6'h01;
    localparam logic [5:0] HALF_DIV16 = 6'h07;
    localparam logic [5:0] HALF_DIV64 = 6'h1f;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        st_idle, st_addr, st_addr_ack, st_rx, st_rx_ack, st_tx, st_tx_ack
    } link_state_e;

    typedef struct packed {
        logic [7:0] own_addr;
        logic [2:0] mode;
        logic [1:0] deb;
        logic en;
        logic icf;
        logic transfer_complete_flag;
        logic address_match_flag;
        logic bus_busy_flag;
        logic transmit_select;
        logic ack_send_bit;
        logic read_write_flag;
        logic match_wakeup_enable;
        logic ack_received_flag;
        logic [7:0] data;
        logic [7:0] rd_data;
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [1:0] sub_sync;
        logic scl_f;
        logic sda_f;
        logic [2:0] scl_cnt;
        logic [2:0] sda_cnt;
        link_state_e st;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic drv;
        logic [5:0] div_cnt;
        logic sck;
        logic wake;
        logic done;
    } slave_state_s;

    localparam slave_state_s STATE_RESET = '{
        mode: MODE_UNUSED, transfer_complete_flag: 1'b1, ack_received_flag: 1'b1,
        scl_sync: 2'h3, sda_sync: 2'h3, scl_f: 1'b1, sda_f: 1'b1,
        st: st_idle, default: '0};

endpackage

// >>> design/serial_slave_address_control.sv
// Two-wire bus slave control, status and address match with SPI clock select
//
// The placing of the registers and the strobed register port were decided locally.

module serial_slave_address_control (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // System hooks
    input wire logic cfg_enable,
    input wire logic low_power,
    input wire logic sub_clock,
    input wire logic timer_match,
    output logic pins_enable,
    output logic wake_req,
    output logic xfer_done,
    output logic spi_sck,
    // Two-wire pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n
);

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [3:0] filt(input logic raw, input logic cur,
                                        input logic [2:0] cnt,
                                        input logic [2:0] lim);
        logic [2:0] c1;
        begin
            c1 = cnt + 3'h1;
            if (raw == cur) begin
                filt = {cur, 3'h0};
            end else if (lim == 3'h0 || c1 >= lim) begin
                filt = {raw, 3'h0};
            end else begin
                filt = {cur, c1};
            end
        end
    endfunction

    function automatic logic [5:0] half_div(input logic [2:0] m);
        begin
            case (m)
                serial_slave_pkg::MODE_SPI_DIV4:
                    half_div = serial_slave_pkg::HALF_DIV4;
                serial_slave_pkg::MODE_SPI_DIV16:
                    half_div = serial_slave_pkg::HALF_DIV16;
                default: half_div = serial_slave_pkg::HALF_DIV64;
            endcase
        end
    endfunction

    serial_slave_pkg::slave_state_s s_reg;
    serial_slave_pkg::slave_state_s s_next;

    logic i2c_mode;
    logic active;
    logic spi_master;
    logic [2:0] deb_lim;
    logic [3:0] scl_fv;
    logic [3:0] sda_fv;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic match;
    logic en_rise;

    assign i2c_mode = s_reg.mode == serial_slave_pkg::MODE_I2C;
    assign active = s_reg.en & cfg_enable & i2c_mode;
    assign spi_master = s_reg.en & cfg_enable &
                        (s_reg.mode <= serial_slave_pkg::MODE_SPI_PTM);

    // Debounce only counts in two-wire mode
    always_comb begin
        if (!i2c_mode || s_reg.deb == serial_slave_pkg::DEB_NONE) begin
            deb_lim = 3'h0;
        end else if (s_reg.deb == serial_slave_pkg::DEB_TWO) begin
            deb_lim = serial_slave_pkg::DEB_TWO_CYC;
        end else begin
            deb_lim = serial_slave_pkg::DEB_FOUR_CYC;
        end
    end

    assign scl_fv = filt(s_reg.scl_sync[1], s_reg.scl_f, s_reg.scl_cnt,
                         deb_lim);
    assign sda_fv = filt(s_reg.sda_sync[1], s_reg.sda_f, s_reg.sda_cnt,
                         deb_lim);
    assign scl_rise = scl_fv[3] & ~s_reg.scl_f;
    assign scl_fall = ~scl_fv[3] & s_reg.scl_f;
    assign start_ev = s_reg.scl_f & scl_fv[3] & s_reg.sda_f & ~sda_fv[3];
    assign stop_ev = s_reg.scl_f & scl_fv[3] & ~s_reg.sda_f & sda_fv[3];
    // Bit 0 of the own address never enters the compare
    assign match = s_reg.shift[7:1] ==
        s_reg.own_addr[serial_slave_pkg::OWN_MSB:serial_slave_pkg::OWN_LSB];
    assign en_rise = wr && addr == serial_slave_pkg::ADDR_CTRL0 &&
                     wdata[serial_slave_pkg::EN_BIT] && !s_reg.en;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.wake = 1'b0;
        s_next.scl_sync = {s_reg.scl_sync[0], scl_in};
        s_next.sda_sync = {s_reg.sda_sync[0], sda_in};
        s_next.sub_sync = {s_reg.sub_sync[0], sub_clock};
        {s_next.scl_f, s_next.scl_cnt} = scl_fv;
        {s_next.sda_f, s_next.sda_cnt} = sda_fv;

        // Software writes land first; link events below override flags
        if (wr) begin
            case (addr)
                serial_slave_pkg::ADDR_OWN: s_next.own_addr = wdata;
                serial_slave_pkg::ADDR_CTRL0: begin
                    s_next.mode = wdata[serial_slave_pkg::MODE_MSB:
                                        serial_slave_pkg::MODE_LSB];
                    s_next.deb = wdata[serial_slave_pkg::DEB_MSB:
                                       serial_slave_pkg::DEB_LSB];
                    s_next.en = wdata[serial_slave_pkg::EN_BIT];
                    s_next.icf = wdata[serial_slave_pkg::ICF_BIT];
                end
                serial_slave_pkg::ADDR_STAT: begin
                    s_next.transmit_select = wdata[serial_slave_pkg::HTX_BIT];
                    s_next.ack_send_bit = wdata[serial_slave_pkg::ACK_SEND_BIT_BIT];
                    s_next.read_write_flag = wdata[serial_slave_pkg::SRW_BIT];
                    s_next.match_wakeup_enable = wdata[serial_slave_pkg::MATCH_WAKEUP_ENABLE_BIT];
                end
                default: s_next.data = wdata;
            endcase
        end

        // SPI settings are left alone on enable; only two-wire flags reset
        if (en_rise && i2c_mode) begin
            s_next.transfer_complete_flag = 1'b1;
            s_next.address_match_flag = 1'b0;
            s_next.bus_busy_flag = 1'b0;
            s_next.read_write_flag = 1'b0;
            s_next.ack_received_flag = 1'b1;
        end

        if (!active) begin
            s_next.st = serial_slave_pkg::st_idle;
            s_next.drv = 1'b0;
            s_next.bit_cnt = 4'h0;
        end else if (start_ev) begin
            s_next.bus_busy_flag = 1'b1;
            s_next.address_match_flag = 1'b0;
            s_next.transfer_complete_flag = 1'b0;
            s_next.drv = 1'b0;
            s_next.bit_cnt = 4'h0;
            s_next.st = serial_slave_pkg::st_addr;
        end else if (stop_ev) begin
            s_next.bus_busy_flag = 1'b0;
            s_next.drv = 1'b0;
            s_next.st = serial_slave_pkg::st_idle;
        end else if (scl_rise) begin
            case (s_reg.st)
                serial_slave_pkg::st_addr, serial_slave_pkg::st_rx: begin
                    s_next.shift = {s_reg.shift[6:0], s_reg.sda_f};
                    s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    s_next.transfer_complete_flag = 1'b0;
                end
                serial_slave_pkg::st_tx: begin
                    s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    s_next.transfer_complete_flag = 1'b0;
                end
                serial_slave_pkg::st_tx_ack: s_next.ack_received_flag = s_reg.sda_f;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (s_reg.st)
                serial_slave_pkg::st_addr: begin
                    if (s_reg.bit_cnt == serial_slave_pkg::BITS_PER_BYTE) begin
                        if (match) begin
                            s_next.address_match_flag = 1'b1;
                            s_next.read_write_flag = s_reg.shift[0];
                            s_next.drv = 1'b1;
                            s_next.transfer_complete_flag = 1'b1;
                            s_next.done = 1'b1;
                            s_next.wake = s_reg.match_wakeup_enable & low_power;
                            s_next.st = serial_slave_pkg::st_addr_ack;
                        end else begin
                            s_next.address_match_flag = 1'b0;
                            s_next.st = serial_slave_pkg::st_idle;
                        end
                    end
                end
                serial_slave_pkg::st_addr_ack, serial_slave_pkg::st_rx_ack: begin
                    s_next.bit_cnt = 4'h0;
                    // The transmit select bit, not the received direction bit, picks the data phase
                    if (s_reg.st == serial_slave_pkg::st_addr_ack &&
                        s_reg.transmit_select) begin
                        s_next.shift = s_reg.data;
                        s_next.drv = ~s_reg.data[7];
                        s_next.st = serial_slave_pkg::st_tx;
                    end else begin
                        s_next.drv = 1'b0;
                        s_next.st = serial_slave_pkg::st_rx;
                    end
                end
                serial_slave_pkg::st_rx: begin
                    if (s_reg.bit_cnt == serial_slave_pkg::BITS_PER_BYTE) begin
                        s_next.data = s_reg.shift;
                        s_next.transfer_complete_flag = 1'b1;
                        s_next.done = 1'b1;
                        s_next.drv = ~s_reg.ack_send_bit;
                        s_next.st = serial_slave_pkg::st_rx_ack;
                    end
                end
                serial_slave_pkg::st_tx: begin
                    if (s_reg.bit_cnt == serial_slave_pkg::BITS_PER_BYTE) begin
                        s_next.drv = 1'b0;
                        s_next.transfer_complete_flag = 1'b1;
                        s_next.done = 1'b1;
                        s_next.st = serial_slave_pkg::st_tx_ack;
                    end else begin
                        s_next.shift = {s_reg.shift[6:0], 1'b0};
                        s_next.drv = ~s_reg.shift[6];
                    end
                end
                serial_slave_pkg::st_tx_ack: begin
                    s_next.bit_cnt = 4'h0;
                    if (!s_reg.ack_received_flag) begin
                        s_next.shift = s_reg.data;
                        s_next.drv = ~s_reg.data[7];
                        s_next.st = serial_slave_pkg::st_tx;
                    end else begin
                        s_next.drv = 1'b0;
                        s_next.st = serial_slave_pkg::st_idle;
                    end
                end
                default: ;
            endcase
        end

        // SPI master clock; the sub clock is sampled, so it is only followed
        if (!spi_master) begin
            s_next.sck = 1'b0;
            s_next.div_cnt = 6'h00;
        end else if (s_reg.mode == serial_slave_pkg::MODE_SPI_SUB) begin
            s_next.sck = s_reg.sub_sync[1];
        end else if (s_reg.mode == serial_slave_pkg::MODE_SPI_PTM) begin
            if (timer_match) begin
                s_next.sck = ~s_reg.sck;
            end
        end else if (s_reg.div_cnt >= half_div(s_reg.mode)) begin
            s_next.div_cnt = 6'h00;
            s_next.sck = ~s_reg.sck;
        end else begin
            s_next.div_cnt = s_reg.div_cnt + 6'h01;
        end

        if (rd) begin
            case (addr)
                serial_slave_pkg::ADDR_OWN: s_next.rd_data = s_reg.own_addr;
                serial_slave_pkg::ADDR_CTRL0: s_next.rd_data = {s_reg.mode,
                    1'b0, s_reg.deb, s_reg.en, s_reg.icf};
                serial_slave_pkg::ADDR_STAT: s_next.rd_data = {s_reg.transfer_complete_flag,
                    s_reg.address_match_flag, s_reg.bus_busy_flag, s_reg.transmit_select, s_reg.ack_send_bit, s_reg.read_write_flag,
                    s_reg.match_wakeup_enable, s_reg.ack_received_flag};
                default: s_next.rd_data = s_reg.data;
            endcase
        end else begin
            s_next.rd_data = 8'h00;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= serial_slave_pkg::STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rd_data;
    assign pins_enable = s_reg.en & cfg_enable;
    assign wake_req = s_reg.wake;
    assign xfer_done = s_reg.done;
    assign spi_sck = s_reg.sck;
    assign sda_out = 1'b0;
    assign sda_oe_n = ~s_reg.drv;

    // ********************************************************
    // Checks
    // ********************************************************
    property p_match_ack;
        @(posedge ref_clk) disable iff (rst)
        (active && !start_ev && !stop_ev && scl_fall && match &&
         s_reg.st == serial_slave_pkg::st_addr && s_reg.bit_cnt == 4'h8)
        |=> s_reg.address_match_flag && !sda_oe_n && s_reg.read_write_flag == $past(s_reg.shift[0]);
    endproperty
    a_match_ack: assert property (p_match_ack) else $error("no ack on match");

    property p_no_match;
        @(posedge ref_clk) disable iff (rst)
        (active && !start_ev && !stop_ev && scl_fall && !match &&
         s_reg.st == serial_slave_pkg::st_addr && s_reg.bit_cnt == 4'h8)
        |=> !s_reg.address_match_flag && sda_oe_n;
    endproperty
    a_no_match: assert property (p_no_match) else $error("false match");

    property p_busy;
        @(posedge ref_clk) disable iff (rst)
        (active && (start_ev || (s_reg.bus_busy_flag && !stop_ev))) |=> s_reg.bus_busy_flag;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not held");

    property p_free;
        @(posedge ref_clk) disable iff (rst)
        (active && stop_ev && !start_ev) |=> !s_reg.bus_busy_flag;
    endproperty
    a_free: assert property (p_free) else $error("busy after stop");

    property p_en_rise;
        @(posedge ref_clk) disable iff (rst)
        (en_rise && i2c_mode) |=> s_reg.transfer_complete_flag && !s_reg.address_match_flag && !s_reg.bus_busy_flag
            && s_reg.ack_received_flag && s_reg.ack_send_bit == $past(s_reg.ack_send_bit);
    endproperty
    a_en_rise: assert property (p_en_rise) else $error("flags not reset");

    property p_release;
        @(posedge ref_clk) disable iff (rst)
        !active |=> sda_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("pin held off");

    property p_rx_ack;
        @(posedge ref_clk) disable iff (rst)
        (active && !start_ev && !stop_ev && scl_fall &&
         s_reg.st == serial_slave_pkg::st_rx && s_reg.bit_cnt == 4'h8)
        |=> sda_oe_n == $past(s_reg.ack_send_bit) && s_reg.transfer_complete_flag && xfer_done;
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("bad ninth bit");

    property p_tx_nack;
        @(posedge ref_clk) disable iff (rst)
        (active && !start_ev && !stop_ev && scl_fall && s_reg.ack_received_flag &&
         s_reg.st == serial_slave_pkg::st_tx_ack)
        |=> sda_oe_n && s_reg.st == serial_slave_pkg::st_idle;
    endproperty
    a_tx_nack: assert property (p_tx_nack) else $error("line kept");

    property p_wake;
        @(posedge ref_clk) disable iff (rst)
        (active && !start_ev && !stop_ev && scl_fall && match &&
         s_reg.match_wakeup_enable && low_power && s_reg.st == serial_slave_pkg::st_addr
         && s_reg.bit_cnt == 4'h8) |=> wake_req ##1 !wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake pulse");

    property p_div4;
        @(posedge ref_clk) disable iff (rst)
        (spi_master && s_reg.mode == serial_slave_pkg::MODE_SPI_DIV4 &&
         $changed(spi_sck)) ##1 (spi_master && s_reg.mode ==
         serial_slave_pkg::MODE_SPI_DIV4) |=> $changed(spi_sck);
    endproperty
    a_div4: assert property (p_div4) else $error("divide by four off");

endmodule // serial_slave_address_control

// >>> tb/i2c_master_model.sv
// Two-wire bus master model driving clock and open-drain data
module i2c_master_model (
    // Clock
    input wire logic ref_clk,
    // Bus
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H = 12;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hold();
        repeat (H) @(posedge ref_clk);
    endtask
    // Data only changes while clock is high for framing
    task automatic start();
        sda_drv <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_drv <= 1'b0;
        hold();
        scl <= 1'b0;
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda_drv <= 1'b1;
        hold();
    endtask
    // Samples late in the high phase, after the slave's filter delay
    task automatic bit_io(input logic b, output logic s);
        sda_drv <= b;
        hold();
        scl <= 1'b1;
        hold();
        s = sda_line;
        scl <= 1'b0;
    endtask
    // Eight bits MSB first, then the ninth bit; direction bit rides in d[0]
    task automatic byte_io(input logic [7:0] d, input logic ai,
                           output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ai, ak);
    endtask
endmodule // i2c_master_model

// >>> tb/tb.sv
// Self-checking bench of the two-wire slave control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, rdata, q;
    logic cfg_enable = 1'b1, low_power = 1'b0, sub_clock = 1'b0;
    logic timer_match = 1'b0, pins_enable, wake_req, xfer_done, spi_sck;
    logic scl, sda_drv, sda_out, sda_oe_n, ak;
    logic [3:0] tick = 4'h0;
    int n_mismatch = 0, checked = 0, n_wake = 0, n_done = 0;
    time t;
    // Released data line is pulled high
    wire sda_line = sda_drv & (sda_oe_n | sda_out);
    localparam logic [7:0] PER [5] = '{8'h04, 8'h10, 8'h40, 8'h10, 8'h10};
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        tick <= tick + 4'h1;
        timer_match <= (tick[2:0] == 3'h4);
        sub_clock <= tick[3];
        n_wake <= n_wake + int'(wake_req === 1'b1);
        n_done <= n_done + int'(xfer_done === 1'b1);
    end
    serial_slave_address_control uut (.ref_clk(ref_clk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cfg_enable(cfg_enable), .low_power(low_power),
        .sub_clock(sub_clock), .timer_match(timer_match),
        .pins_enable(pins_enable), .wake_req(wake_req),
        .xfer_done(xfer_done), .spi_sck(spi_sck), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
    i2c_master_model m (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic chk(input logic [1:0] a, input logic [7:0] e, mk,
                       input string nm);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 check(nm, e & mk, rdata & mk);
        @(posedge ref_clk);
    endtask
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk(0, 8'h00, 8'hff, "own");
        chk(1, 8'he0, 8'hff, "ctrl0");
        chk(2, 8'h81, 8'hff, "status");
        reg_wr(0, 8'h5b);
        chk(0, 8'h5b, 8'hff, "own");
        reg_wr(1, 8'hc6);
        check("pins", 8'h01, {7'h0, pins_enable});
        cfg_enable <= 1'b0;
        @(posedge ref_clk);
        check("pins", 8'h00, {7'h0, pins_enable});
        cfg_enable <= 1'b1;
        low_power <= 1'b1;
        reg_wr(2, 8'h02);
        $display("test registers done");
        m.start();
        m.byte_io(8'h5a, 1'b1, q, ak);
        check("addr ack", 8'h00, {7'h0, ak});
        check("wake", 8'h01, 8'(n_wake));
        chk(2, 8'he3, 8'hff, "status");
        low_power <= 1'b0;
        reg_wr(2, 8'h00);
        m.byte_io(8'h3c, 1'b1, q, ak);
        check("data ack", 8'h00, {7'h0, ak});
        chk(3, 8'h3c, 8'hff, "data");
        check("done", 8'h02, 8'(n_done));
        reg_wr(2, 8'h08);
        m.byte_io(8'h77, 1'b1, q, ak);
        check("data nack", 8'h01, {7'h0, ak});
        reg_wr(2, 8'h00);
        m.stop();
        chk(2, 8'h00, 8'h20, "busy");
        m.start();
        m.byte_io(8'h5c, 1'b1, q, ak);
        check("other ack", 8'h01, {7'h0, ak});
        chk(2, 8'h00, 8'h40, "match");
        m.stop();
        $display("test receive done");
        reg_wr(3, 8'hc3);
        reg_wr(2, 8'h10);
        m.start();
        m.byte_io(8'h5b, 1'b1, q, ak);
        check("addr ack", 8'h00, {7'h0, ak});
        chk(2, 8'h04, 8'h04, "dir");
        m.byte_io(8'hff, 1'b0, q, ak);
        check("tx byte", 8'hc3, q);
        chk(2, 8'h00, 8'h01, "rx ack");
        m.byte_io(8'hff, 1'b1, q, ak);
        check("tx byte", 8'hc3, q);
        chk(2, 8'h01, 8'h01, "rx ack");
        m.bit_io(1'b1, ak);
        check("release", 8'h01, {7'h0, ak});
        m.stop();
        $display("test transmit done");
        reg_wr(2, 8'h1c);
        reg_wr(1, 8'hc4);
        reg_wr(1, 8'hc6);
        chk(2, 8'h99, 8'hff, "status");
        reg_wr(1, 8'h00);
        reg_wr(1, 8'h02);
        chk(0, 8'h5b, 8'hff, "own");
        for (int i = 0; i < 5; i++) begin
            reg_wr(1, {3'(i), 5'h02});
            @(posedge spi_sck);
            t = $time;
            @(posedge spi_sck);
            check("sck period", PER[i], 8'(($time - t) / 10));
            @(posedge ref_clk);
        end
        // SPI slave takes its clock from outside, so no clock comes out
        reg_wr(1, 8'ha2);
        repeat (8) @(posedge ref_clk);
        check("slave sck", 8'h00, {7'h0, spi_sck});
        $display("test clocks done");
        tally_and_finish();
    end
endmodule // tb
